// >>> dlp_top.sv
// Delayed line pulse regeneration, freeze control, lock-loss and loop settings
// What this block does
// RL1 - With line pulse and inverted counter output both low the pulse goes low.
// RL2 - With line pulse high and inverted counter output low the pulse keeps its level.
// RL3 - With inverted counter output high the pulse goes high whatever the line pulse.
// RL4 - While the loop is frozen the freeze-select setting decides the pulse output.
// RL5 - In freeze without hold selected the output also follows the polarity and counter-route settings.
// RL6 - With no phase error, so the loop is locked, lock-loss stays low.
// RL7 - Lock-loss goes high once the integrated error falls below the threshold.
// RL8 - Pump gain selects 100, 200, 400 or 800 microamp per two pi radians.
// RL9 - A post-oscillator divider selects divide by 1, 2, 4 or 8.
// RL10 - Pulse storage is a JK element on the pixel clock, inverted output used.
module dlp_top (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Pins, asynchronous
	input  wire logic        line_pulse_pin,
	input  wire logic        loop_freeze_pin,
	// Same-clock loop signals
	input  wire logic        counter_out_inv,
	input  wire logic        phase_err_pulse,
	// Outputs
	output logic             delayed_line_pulse,
	output logic             lock_loss,
	output logic [9:0]       pump_gain_ua,
	output logic             osc_div_tick,
	output logic             irq
);

	dlp_pkg::dlp_ctrl_s     ctrl, next_ctrl;
	dlp_pkg::dlp_lock_cfg_s lcfg, next_lcfg;
	dlp_pkg::dlp_bus_e      bus_st, next_bus_st;
	logic [31:0]            next_readdata;
	logic [2:0]             irq_status, next_irq_status;
	logic [2:0]             irq_mask, next_irq_mask;
	logic [2:0]             irq_event;

	logic [1:0] line_sync_ff;
	logic [1:0] freeze_sync_ff;
	logic       line_sync;
	logic       frozen;
	logic       frozen_d;

	logic       jk_pulse;
	logic       hold_jk;
	logic       next_pulse;
	logic [7:0] integ, next_integ;
	logic       next_lock_loss;
	logic [9:0] next_pump_gain_ua;
	logic [2:0] div_cnt, next_div_cnt;
	logic [2:0] div_last;
	logic       next_div_tick;
	logic       wr_ack;

	function automatic logic [7:0] sat_step(input logic [7:0] v,
		input logic [3:0] s, input logic up);
		logic [8:0] t;
		t = 9'h000;
		if (up) begin
			t = {1'b0, v} + {5'h00, s};
			sat_step = t[8] ? 8'hFF : t[7:0];
		end else begin
			sat_step = (v < {4'h0, s}) ? 8'h00 : v - {4'h0, s};
		end
	endfunction

	// Two-stage synchronisers for the pins
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			line_sync_ff   <= 2'h0;
			freeze_sync_ff <= 2'h0;
			frozen_d       <= 1'b0;
		end else begin
			line_sync_ff   <= {line_sync_ff[0], line_pulse_pin};
			freeze_sync_ff <= {freeze_sync_ff[0], loop_freeze_pin};
			frozen_d       <= freeze_sync_ff[1];
		end
	end

	assign line_sync = line_sync_ff[1];
	assign frozen    = freeze_sync_ff[1];

	// Freeze with hold selected stops the element so the pulse is kept
	assign hold_jk = frozen & ctrl.pulse_freeze_sel; // RL4

	dlp_pulse_hold dlp_pulse_hold_inst (
		.clk_sys            (clk_sys),
		.resetn             (resetn),
		.line_pulse         (line_sync),
		.counter_out_inv    (counter_out_inv),
		.hold_en            (hold_jk),
		.delayed_line_pulse (jk_pulse)
	); // RL1 RL2 RL3 RL10

	// Output stage: route, polarity and freeze hold
	always_comb begin
		next_pulse = delayed_line_pulse;
		if (!hold_jk) begin // RL4
			next_pulse = (ctrl.counter_route_sel ? counter_out_inv : jk_pulse)
				^ ~ctrl.pulse_polarity_sel; // RL5
		end
	end

	// Lock-loss integrator: error pulses drain it, quiet cycles refill it
	always_comb begin
		next_integ = sat_step(integ, phase_err_pulse ? lcfg.fall_step
			: lcfg.rise_step, ~phase_err_pulse);
		next_lock_loss = integ < lcfg.threshold; // RL6 RL7
	end

	// Pump gain and post-oscillator divider
	always_comb begin
		next_pump_gain_ua = dlp_pkg::PUMP_BASE_UA << ctrl.pump_gain; // RL8
		div_last = 3'((4'h1 << ctrl.post_osc_divider) - 4'h1);
		if (div_cnt == 3'h0 || div_cnt > div_last) begin
			next_div_cnt = div_last; // RL9
		end else begin
			next_div_cnt = div_cnt - 3'h1;
		end
		next_div_tick = div_cnt == 3'h0;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			delayed_line_pulse <= 1'b0;
			integ              <= dlp_pkg::INTEG_FULL;
			lock_loss          <= 1'b0;
			pump_gain_ua       <= 10'h000;
			div_cnt            <= 3'h0;
			osc_div_tick       <= 1'b0;
		end else begin
			delayed_line_pulse <= next_pulse;
			integ              <= next_integ;
			lock_loss          <= next_lock_loss;
			pump_gain_ua       <= next_pump_gain_ua;
			div_cnt            <= next_div_cnt;
			osc_div_tick       <= next_div_tick;
		end
	end

	// Interrupt events
	assign irq_event[dlp_pkg::IRQ_UNLOCK_POS] = next_lock_loss & ~lock_loss;
	assign irq_event[dlp_pkg::IRQ_RELOCK_POS] = ~next_lock_loss & lock_loss;
	assign irq_event[dlp_pkg::IRQ_FREEZE_POS] = frozen & ~frozen_d;

	// Bus slave: one wait cycle, then answer; writes land on the ack cycle
	assign wr_ack          = (bus_st == dlp_pkg::DLP_BUS_ACK) & avs_write;
	assign avs_waitrequest = bus_st != dlp_pkg::DLP_BUS_ACK;

	always_comb begin
		next_bus_st     = bus_st;
		next_readdata   = avs_readdata;
		next_ctrl       = ctrl;
		next_lcfg       = lcfg;
		next_irq_mask   = irq_mask;
		next_irq_status = irq_status;
		unique case (bus_st)
			dlp_pkg::DLP_BUS_IDLE: begin
				if (avs_read || avs_write) begin
					next_bus_st   = dlp_pkg::DLP_BUS_ACK;
					next_readdata = 32'h0000_0000;
					if (avs_read) begin
						unique case ({avs_address[4:2], 2'b00})
							dlp_pkg::ADDR_CTRL:
								next_readdata[9:0] = {ctrl.post_osc_divider,
									2'b00, ctrl.pump_gain, 1'b0,
									ctrl.counter_route_sel,
									ctrl.pulse_polarity_sel,
									ctrl.pulse_freeze_sel};
							dlp_pkg::ADDR_STATUS: begin
								next_readdata[dlp_pkg::STAT_LOCK_LOSS_POS] = lock_loss;
								next_readdata[dlp_pkg::STAT_PULSE_POS]     =
									delayed_line_pulse;
								next_readdata[dlp_pkg::STAT_FROZEN_POS]    = frozen;
								next_readdata[dlp_pkg::STAT_INTEG_POS +: 8] = integ;
							end
							dlp_pkg::ADDR_IRQ_STAT:
								next_readdata[2:0] = irq_status;
							dlp_pkg::ADDR_IRQ_MASK:
								next_readdata[2:0] = irq_mask;
							dlp_pkg::ADDR_LOCK_CFG:
								next_readdata[15:0] = lcfg;
							default:
								next_readdata = 32'h0000_0000;
						endcase
					end
				end
			end
			dlp_pkg::DLP_BUS_ACK: begin
				next_bus_st = dlp_pkg::DLP_BUS_IDLE;
				if (wr_ack) begin
					unique case ({avs_address[4:2], 2'b00})
						dlp_pkg::ADDR_CTRL: begin
							next_ctrl.pulse_freeze_sel   =
								avs_writedata[dlp_pkg::CTRL_FREEZE_SEL_POS];
							next_ctrl.pulse_polarity_sel =
								avs_writedata[dlp_pkg::CTRL_POLARITY_POS];
							next_ctrl.counter_route_sel  =
								avs_writedata[dlp_pkg::CTRL_ROUTE_POS];
							next_ctrl.pump_gain          =
								avs_writedata[dlp_pkg::CTRL_PUMP_GAIN_POS +: 2];
							next_ctrl.post_osc_divider   =
								avs_writedata[dlp_pkg::CTRL_DIVIDER_POS +: 2];
						end
						dlp_pkg::ADDR_IRQ_STAT:
							next_irq_status = irq_status & ~avs_writedata[2:0];
						dlp_pkg::ADDR_IRQ_MASK:
							next_irq_mask = avs_writedata[2:0];
						dlp_pkg::ADDR_LOCK_CFG:
							next_lcfg = avs_writedata[15:0];
						default: ;
					endcase
				end
			end
		endcase
		// Set after clear so a same-cycle event survives
		next_irq_status = next_irq_status | irq_event;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			bus_st       <= dlp_pkg::DLP_BUS_IDLE;
			avs_readdata <= 32'h0000_0000;
			ctrl         <= dlp_pkg::RST_CTRL;
			lcfg         <= {dlp_pkg::RST_RISE_STEP, dlp_pkg::RST_FALL_STEP,
				dlp_pkg::RST_THRESHOLD};
			irq_mask     <= dlp_pkg::RST_IRQ_MASK;
			irq_status   <= 3'h0;
			irq          <= 1'b0;
		end else begin
			bus_st       <= next_bus_st;
			avs_readdata <= next_readdata;
			ctrl         <= next_ctrl;
			lcfg         <= next_lcfg;
			irq_mask     <= next_irq_mask;
			irq_status   <= next_irq_status;
			irq          <= |(next_irq_status & next_irq_mask);
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	property p_rl1;
		!line_sync && !counter_out_inv && !hold_jk |=> !jk_pulse;
	endproperty
	a_rl1: assert property (p_rl1) else $error("pulse not low"); // RL1

	property p_rl2;
		line_sync && !counter_out_inv |=> $stable(jk_pulse);
	endproperty
	a_rl2: assert property (p_rl2) else $error("pulse not held"); // RL2

	property p_rl3;
		counter_out_inv && !hold_jk |=> jk_pulse;
	endproperty
	a_rl3: assert property (p_rl3) else $error("pulse not high"); // RL3

	property p_rl4;
		hold_jk ##1 hold_jk |-> $stable(delayed_line_pulse);
	endproperty
	a_rl4: assert property (p_rl4) else $error("frozen pulse moved"); // RL4

	property p_rl5;
		!hold_jk && ctrl.counter_route_sel
			|=> delayed_line_pulse ==
				($past(counter_out_inv) ^ ~$past(ctrl.pulse_polarity_sel));
	endproperty
	a_rl5: assert property (p_rl5) else $error("route or polarity wrong"); // RL5

	property p_rl6;
		integ == dlp_pkg::INTEG_FULL |=> !lock_loss;
	endproperty
	a_rl6: assert property (p_rl6) else $error("lock loss while locked"); // RL6

	property p_rl7;
		integ < lcfg.threshold |=> lock_loss;
	endproperty
	a_rl7: assert property (p_rl7) else $error("lock loss missed"); // RL7

	property p_rl8;
		ctrl.pump_gain == 2'h3 |=> pump_gain_ua == 10'h320;
	endproperty
	a_rl8: assert property (p_rl8) else $error("pump gain not 800"); // RL8

	// Abandoned once the ratio is rewritten, the old period no longer applies
	property p_rl9;
		disable iff (!resetn || ctrl.post_osc_divider != 2'h3)
		(ctrl.post_osc_divider == 2'h3) [*8] ##1 osc_div_tick
			|=> !osc_div_tick [*7] ##1 osc_div_tick;
	endproperty
	a_rl9: assert property (p_rl9) else $error("divide by 8 wrong"); // RL9

	property p_rl10;
		!line_sync && !counter_out_inv && !hold_jk
			##1 line_sync && !counter_out_inv |=> !jk_pulse;
	endproperty
	a_rl10: assert property (p_rl10) else $error("stored low lost"); // RL10

	property p_irq;
		|(irq_status & irq_mask) |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not raised");

	c_unlock: cover property ($rose(lock_loss));
	c_freeze: cover property (hold_jk [*4]);
	c_route:  cover property (ctrl.counter_route_sel && $rose(delayed_line_pulse));
	c_write:  cover property (wr_ack);

endmodule // dlp_top

// >>> dlp_pkg.sv
// Package: register map, field layout and types of the delayed line pulse block
package dlp_pkg;

	// Register byte offsets
	localparam logic [4:0] ADDR_CTRL     = 5'h00;
	localparam logic [4:0] ADDR_STATUS   = 5'h04;
	localparam logic [4:0] ADDR_IRQ_STAT = 5'h08;
	localparam logic [4:0] ADDR_IRQ_MASK = 5'h0C;
	localparam logic [4:0] ADDR_LOCK_CFG = 5'h10;

	// CTRL field positions
	localparam int CTRL_FREEZE_SEL_POS = 0;
	localparam int CTRL_POLARITY_POS   = 1;
	localparam int CTRL_ROUTE_POS      = 2;
	localparam int CTRL_PUMP_GAIN_POS  = 4;
	localparam int CTRL_DIVIDER_POS    = 8;

	// STATUS field positions
	localparam int STAT_LOCK_LOSS_POS  = 0;
	localparam int STAT_PULSE_POS      = 1;
	localparam int STAT_FROZEN_POS     = 2;
	localparam int STAT_INTEG_POS      = 8;

	// Interrupt bit positions
	localparam int IRQ_UNLOCK_POS      = 0;
	localparam int IRQ_RELOCK_POS      = 1;
	localparam int IRQ_FREEZE_POS      = 2;
	localparam int IRQ_W               = 3;

	// LOCK_CFG field positions
	localparam int LCFG_THR_POS        = 0;
	localparam int LCFG_FALL_POS       = 8;
	localparam int LCFG_RISE_POS       = 12;

	// Reset values
	localparam logic [2:0] RST_IRQ_MASK  = 3'h0;
	localparam logic [7:0] RST_THRESHOLD = 8'h80;
	localparam logic [3:0] RST_FALL_STEP = 4'h4;
	localparam logic [3:0] RST_RISE_STEP = 4'h1;
	localparam logic [7:0] INTEG_FULL    = 8'hFF;

	// Pump gain base step, microamp per two pi radians
	localparam logic [9:0] PUMP_BASE_UA  = 10'h064;

	typedef struct packed {
		logic [1:0] post_osc_divider;
		logic [1:0] pump_gain;
		logic       counter_route_sel;
		logic       pulse_polarity_sel;
		logic       pulse_freeze_sel;
	} dlp_ctrl_s;

	localparam dlp_ctrl_s RST_CTRL = '{
		post_osc_divider:   2'h0,
		pump_gain:          2'h2,
		counter_route_sel:  1'b0,
		pulse_polarity_sel: 1'b1,
		pulse_freeze_sel:   1'b0
	};

	typedef struct packed {
		logic [3:0] rise_step;
		logic [3:0] fall_step;
		logic [7:0] threshold;
	} dlp_lock_cfg_s;

	typedef enum logic {
		DLP_BUS_IDLE,
		DLP_BUS_ACK
	} dlp_bus_e;

endpackage

// >>> dlp_pulse_hold.sv
// JK-style hold element that regenerates the delayed line pulse
module dlp_pulse_hold (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// Pulse inputs
	input  wire logic line_pulse,
	input  wire logic counter_out_inv,
	input  wire logic hold_en,
	// Regenerated pulse, inverted state of the element
	output logic      delayed_line_pulse
);

	logic q;
	logic next_q;
	logic j;
	logic k;

	always_comb begin
		j = ~line_pulse & ~counter_out_inv;
		k = counter_out_inv;
		next_q = q;
		if (!hold_en) begin
			unique case ({j, k})
				2'b00: next_q = q;
				2'b01: next_q = 1'b0;
				2'b10: next_q = 1'b1;
				2'b11: next_q = ~q;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			q <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	assign delayed_line_pulse = ~q;

endmodule // dlp_pulse_hold

// >>> dlp_sync_src.sv
// Model of the sync source and loop signals that feed the block
module dlp_sync_src (
	// Clock
	input  wire logic clk_sys,
	// Levels asked for by the bench
	input  wire logic want_line,
	input  wire logic want_cnt,
	input  wire logic want_frz,
	input  wire logic want_err,
	// Lines into the block
	output logic      line_pulse_pin,
	output logic      counter_out_inv,
	output logic      loop_freeze_pin,
	output logic      phase_err_pulse
);
	timeunit 1ns;
	timeprecision 1ps;

	// Quiet lines until the first edge, then levels move only after an edge
	initial begin
		{line_pulse_pin, counter_out_inv} = 2'h0;
		{loop_freeze_pin, phase_err_pulse} = 2'h0;
	end

	always @(posedge clk_sys) begin
		line_pulse_pin  <= want_line;
		counter_out_inv <= want_cnt;
		loop_freeze_pin <= want_frz;
		phase_err_pulse <= want_err;
	end
endmodule // dlp_sync_src

// >>> tb_top.sv
// Self-checking bench of the delayed line pulse block
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys, resetn;
	logic [4:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic        line_pulse_pin, loop_freeze_pin;
	logic        counter_out_inv, phase_err_pulse;
	logic        want_line, want_cnt, want_frz, want_err;
	logic        delayed_line_pulse, lock_loss, osc_div_tick, irq;
	logic [9:0]  pump_gain_ua;
	int          mismatches, checks_done, ticks, t0;

	dlp_top dlp_top_inst (
		.clk_sys(clk_sys), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.line_pulse_pin(line_pulse_pin), .loop_freeze_pin(loop_freeze_pin),
		.counter_out_inv(counter_out_inv), .phase_err_pulse(phase_err_pulse),
		.delayed_line_pulse(delayed_line_pulse), .lock_loss(lock_loss),
		.pump_gain_ua(pump_gain_ua), .osc_div_tick(osc_div_tick), .irq(irq)
	);

	dlp_sync_src dlp_sync_src_inst (
		.clk_sys(clk_sys), .want_line(want_line), .want_cnt(want_cnt),
		.want_frz(want_frz), .want_err(want_err),
		.line_pulse_pin(line_pulse_pin), .counter_out_inv(counter_out_inv),
		.loop_freeze_pin(loop_freeze_pin), .phase_err_pulse(phase_err_pulse)
	);

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Counted on the falling edge so a window of rising edges is exact
	always @(negedge clk_sys) begin
		if (osc_div_tick === 1'b1)
			ticks++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One Avalon access, held until waitrequest is seen low
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			mismatches++;
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
		repeat (3) @(posedge clk_sys);
	endtask

	// Levels as {line, counter, freeze, error}, then wait k edges
	task automatic step(input logic [3:0] v, input int k);
		@(posedge clk_sys);
		{want_line, want_cnt, want_frz, want_err} <= v;
		repeat (k) @(posedge clk_sys);
	endtask

	task final_report;
		$display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A healthy run is well under 2000 cycles
	initial begin
		#100000;
		mismatches++;
		final_report;
	end

	initial begin
		{avs_address, avs_read, avs_write, avs_writedata} = '0;
		{want_line, want_cnt, want_frz, want_err} = 4'h0;
		{mismatches, checks_done, ticks} = '0;
		resetn = 1'b0;
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		acc(1'b0, 5'h00, 32'h0, rd);
		chk(rd, 32'h00000022);
		chk(32'(pump_gain_ua), 32'h190);
		acc(1'b0, 5'h10, 32'h0, rd);
		chk(rd, 32'h00001480);
		wr(5'h10, 32'h00002390);
		acc(1'b0, 5'h10, 32'h0, rd);
		chk(rd, 32'h00002390);
		wr(5'h10, 32'h00001480);
		acc(1'b0, 5'h0C, 32'h0, rd);
		chk(rd, 32'h0);
		wr(5'h14, 32'hFFFFFFFF);
		acc(1'b0, 5'h14, 32'h0, rd);
		chk(rd, 32'h0);
		for (int g = 0; g < 4; g++) begin
			wr(5'h00, 32'h02 | (g << 4));
			chk(32'(pump_gain_ua), 32'h064 << g);
		end
		for (int v = 0; v < 4; v++) begin
			wr(5'h00, 32'h22 | (v << 8));
			t0 = ticks;
			repeat (16) @(posedge clk_sys);
			chk(ticks - t0, 32'd16 >> v);
		end
		wr(5'h00, 32'h22);
		step(4'b0100, 8);
		chk(32'(delayed_line_pulse), 32'h1);
		step(4'b1100, 8);
		chk(32'(delayed_line_pulse), 32'h1);
		step(4'b1000, 8);
		chk(32'(delayed_line_pulse), 32'h1);
		step(4'b0000, 8);
		chk(32'(delayed_line_pulse), 32'h0);
		step(4'b1000, 8);
		chk(32'(delayed_line_pulse), 32'h0);
		step(4'b0100, 8);
		wr(5'h00, 32'h23);
		step(4'b0110, 8);
		step(4'b0010, 8);
		chk(32'(delayed_line_pulse), 32'h1);
		wr(5'h00, 32'h22);
		chk(32'(delayed_line_pulse), 32'h0);
		wr(5'h00, 32'h20);
		chk(32'(delayed_line_pulse), 32'h1);
		wr(5'h00, 32'h26);
		step(4'b1110, 8);
		chk(32'(delayed_line_pulse), 32'h1);
		step(4'b1010, 8);
		chk(32'(delayed_line_pulse), 32'h0);
		wr(5'h00, 32'h22);
		step(4'b0000, 40);
		chk(32'(lock_loss), 32'h0);
		wr(5'h0C, 32'h1);
		acc(1'b0, 5'h08, 32'h0, rd);
		chk(rd, 32'h4);
		wr(5'h08, 32'h7);
		chk(32'(irq), 32'h0);
		step(4'b0001, 28);
		chk(32'(lock_loss), 32'h0);
		step(4'b0001, 12);
		chk(32'(lock_loss), 32'h1);
		chk(32'(irq), 32'h1);
		acc(1'b0, 5'h04, 32'h0, rd);
		chk(rd & 32'h1, 32'h1);
		step(4'b0000, 2);
		wr(5'h0C, 32'h0);
		chk(32'(irq), 32'h0);
		wr(5'h0C, 32'h1);
		chk(32'(irq), 32'h1);
		wr(5'h08, 32'h1);
		chk(32'(irq), 32'h0);
		final_report;
	end
endmodule // tb_top
